//--- core/uart_irq_cfg.svh
// offsets, field positions, reset values and timing counts of the channel control block
`ifndef UART_IRQ_CFG_SVH
`define UART_IRQ_CFG_SVH

// register byte addresses (one aligned word each)
`define OFS_RX_TX_HOLD 12'h000
`define OFS_IRQ_ENABLE 12'h004
`define OFS_IRQ_IDENT 12'h008
`define OFS_FIFO_CTRL 12'h00c
`define OFS_LINE_CTRL 12'h010
`define OFS_MODEM_CTRL 12'h014
`define OFS_LINE_STAT 12'h018
`define OFS_MODEM_STAT 12'h01c
`define OFS_SCRATCH 12'h020
`define OFS_DIV_LOW 12'h024
`define OFS_DIV_HIGH 12'h028
`define OFS_ENH_FEAT 12'h02c
`define OFS_FLOW_THRESH 12'h030
`define OFS_TRIG_LEVEL 12'h034
`define OFS_RESUME_ONE 12'h038
`define OFS_RESUME_TWO 12'h03c
`define OFS_HALT_ONE 12'h040
`define OFS_HALT_TWO 12'h044
`define OFS_FIFO_LEVEL 12'h048

// reset values
`define RST_LINE_CTRL 8'h1d
`define RST_IRQ_IDENT 8'h01
`define RST_LINE_STAT 8'h60

// identification codes
`define ID_NONE 6'h01
`define ID_LINE 6'h06
`define ID_TIMEOUT 6'h0c
`define ID_RXDATA 6'h04
`define ID_TXHOLD 6'h02
`define ID_MODEM 6'h00
`define ID_FLOW 6'h10
`define ID_HSHAKE 6'h20

// field positions
`define FC_FIFO_EN 0
`define FC_DMA_MODE 3
`define LS_DATA 0
`define LS_OVERRUN 1
`define LS_ERR_SUM 7
`define IE_HSHAKE_LO 6

// timing: character of idle before receive time-out, in ns at 10 MHz
`define TIMEOUT_NS 4000
`define CLK_NS 100
`define TIMEOUT_CYC ((`TIMEOUT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

//--- core/uart_irq_pkg.sv
// types shared by the channel control block
package uart_irq_pkg;
   // interrupt source index, in falling priority
   typedef enum logic [6:0] {
      src_line = 7'b0000001,
      src_timeout = 7'b0000010,
      src_rxdata = 7'b0000100,
      src_txhold = 7'b0001000,
      src_modem = 7'b0010000,
      src_flow = 7'b0100000,
      src_hshake = 7'b1000000
   } irq_src_e;
   typedef logic [7:0] byte_t;
endpackage

//--- core/uart_irq_ctl.sv
// per-channel interrupt, reset and dma-ready control of a uart channel
//
// Function
// (R1) reset clears control regs, line ctrl 1d
// (R2) identification reads 01 after reset
// (R3) line status resets to bits 5,6 set
// (R4) modem status deltas cleared, pins mirrored
// (R5) divisor, scratch, flow chars not reset
// (R6) serial outs high, tx ready low in reset
// (R7) seven enabled sources drive one irq
// (R8) identification codes in fixed priority
// (R9) line status irq cleared per error kind
// (R10) rx data, timeout clear on holding read
// (R11) tx hold clear on ident read/write
// (R12) rts/cts rising edge, cleared ident read
// (R13) error summary while errored chars remain
// (R14) head char errors shown, zero when empty
// (R15) halt cleared by resume, special by lsr
// (R16) low enable bits select interrupt mode
// (R17) enables cleared keep irq inactive
// (R18) fifo ctrl bit3 selects dma mode
// (R19) host never mixes software and pin flow
// (R20) single mode ready per character
// (R21) block mode ready by trigger levels
// (R22) halt char sets bit4 when enabled
// (R23) only highest pending source reported
`timescale 1ns/100ps
`default_nettype none
`include "uart_irq_cfg.svh"

module uart_irq_ctl
   import uart_irq_pkg::*;
#(
   parameter int DEPTH = 64, // fifo depth
   parameter int TO_CYC = `TIMEOUT_CYC // receive time-out cycles
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] rx_char, // received char from the receiver
   input wire logic [2:0] rx_char_err, // break, framing, parity of it
   input wire logic rx_char_valid, // one-cycle push strobe
   input wire logic tx_pop, // transmitter took one char
   input wire logic cts_n_pin, // modem pins, asynchronous
   input wire logic dsr_n_pin,
   input wire logic ri_n_pin,
   input wire logic cd_n_pin,
   input wire logic halt_seen, // halt char detected, pulse
   input wire logic resume_seen, // resume char detected, pulse
   input wire logic special_seen, // special char detected, pulse
   output logic serial_out,
   output logic rts_n,
   output logic dtr_n,
   output logic rx_dma_request,
   output logic tx_dma_request,
   output logic irq,
   output logic [7:0] tx_char, // head of transmit fifo
   output logic tx_char_valid
);
   localparam int AW = $clog2(DEPTH);

   // refuse depths that the pointer and count widths cannot serve
   if (DEPTH < 4 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0) begin : bad_depth
      $error("DEPTH must be a power of two from 4 to 128");
   end
   if (TO_CYC < 1) begin : bad_timeout
      $error("TO_CYC must be at least 1");
   end

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic wr_en; // write takes effect
   logic rd_en; // read data taken
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign pready = 1'b1; // zero wait states
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction
   function automatic logic mapped(input logic [11:0] a);
      return a[1:0] == 2'b00 && a <= `OFS_FIFO_LEVEL;
   endfunction
   assign pslverr = psel & penable & ~mapped(paddr);

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   byte_t irq_enable_reg_r, fifo_ctrl_reg_r, line_ctrl_reg_r, modem_ctrl_reg_r;
   byte_t enhanced_feat_reg_r, flow_threshold_reg_r, trigger_level_reg_r;
   // (R1) control regs take their reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable_reg_r <= 8'h00;
         fifo_ctrl_reg_r <= 8'h00;
         line_ctrl_reg_r <= `RST_LINE_CTRL;
         modem_ctrl_reg_r <= 8'h00;
         enhanced_feat_reg_r <= 8'h00;
         flow_threshold_reg_r <= 8'h00;
         trigger_level_reg_r <= 8'h00;
      end else if (wr_en) begin
         if (hit(paddr, `OFS_IRQ_ENABLE)) irq_enable_reg_r <= pwdata[7:0];
         if (hit(paddr, `OFS_FIFO_CTRL)) fifo_ctrl_reg_r <= pwdata[7:0];
         if (hit(paddr, `OFS_LINE_CTRL)) line_ctrl_reg_r <= pwdata[7:0];
         if (hit(paddr, `OFS_MODEM_CTRL)) modem_ctrl_reg_r <= pwdata[7:0];
         if (hit(paddr, `OFS_ENH_FEAT)) enhanced_feat_reg_r <= pwdata[7:0];
         if (hit(paddr, `OFS_FLOW_THRESH)) flow_threshold_reg_r <= pwdata[7:0];
         if (hit(paddr, `OFS_TRIG_LEVEL)) trigger_level_reg_r <= pwdata[7:0];
      end
   end

   // (R5) these keep content across reset: no reset branch
   byte_t scratchpad_reg_r, divisor_low_r, divisor_high_r;
   byte_t resume_char_one_r, resume_char_two_r, halt_char_one_r, halt_char_two_r;
   always_ff @(posedge pclk) begin
      if (wr_en) begin
         if (hit(paddr, `OFS_SCRATCH)) scratchpad_reg_r <= pwdata[7:0];
         if (hit(paddr, `OFS_DIV_LOW)) divisor_low_r <= pwdata[7:0];
         if (hit(paddr, `OFS_DIV_HIGH)) divisor_high_r <= pwdata[7:0];
         if (hit(paddr, `OFS_RESUME_ONE)) resume_char_one_r <= pwdata[7:0];
         if (hit(paddr, `OFS_RESUME_TWO)) resume_char_two_r <= pwdata[7:0];
         if (hit(paddr, `OFS_HALT_ONE)) halt_char_one_r <= pwdata[7:0];
         if (hit(paddr, `OFS_HALT_TWO)) halt_char_two_r <= pwdata[7:0];
      end
   end

   logic fifo_en, dma_block;
   assign fifo_en = fifo_ctrl_reg_r[`FC_FIFO_EN];
   // (R18) block mode only with fifos on and mode bit set
   assign dma_block = fifo_en & fifo_ctrl_reg_r[`FC_DMA_MODE];
   // trigger levels in chars: nibble*4, or 1 with zero / fifos off
   logic [7:0] rx_trig, tx_trig;
   assign rx_trig = (!fifo_en || trigger_level_reg_r[7:4] == 4'h0) ? 8'h01
                    : {2'b00, trigger_level_reg_r[7:4], 2'b00};
   assign tx_trig = (!fifo_en || trigger_level_reg_r[3:0] == 4'h0) ? 8'h01
                    : {2'b00, trigger_level_reg_r[3:0], 2'b00};

   // ------------------------------------------------------------
   // receive fifo with per-char error bits
   // ------------------------------------------------------------
   logic [10:0] rx_mem [DEPTH]; // char + 3 error bits
   logic [AW:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
   logic [7:0] rx_cnt, tx_cnt;
   logic [7:0] err_cnt_r; // erroneous chars stored
   logic rx_rd, rx_push, rx_pop, overrun;
   logic [7:0] cap; // effective depth
   assign cap = fifo_en ? 8'(DEPTH) : 8'h01;
   // braces keep the difference at pointer width so a wrap stays modulo
   assign rx_cnt = 8'({rx_wp_r - rx_rp_r});
   assign tx_cnt = 8'({tx_wp_r - tx_rp_r});
   assign rx_rd = rd_en & hit(paddr, `OFS_RX_TX_HOLD);
   assign rx_push = rx_char_valid & (rx_cnt < cap);
   assign overrun = rx_char_valid & (rx_cnt >= cap);
   assign rx_pop = rx_rd & (rx_cnt != 8'h00);
   logic [10:0] rx_head;
   assign rx_head = rx_mem[rx_rp_r[AW-1:0]];

   always_ff @(posedge pclk) begin
      if (rx_push) rx_mem[rx_wp_r[AW-1:0]] <= {rx_char_err, rx_char};
   end
   // (R1) fifo pointers cleared on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_wp_r <= '0;
         rx_rp_r <= '0;
      end else begin
         if (rx_push) rx_wp_r <= rx_wp_r + 1'b1;
         if (rx_pop) rx_rp_r <= rx_rp_r + 1'b1;
      end
   end
   // (R13) count errored chars; summary stays until none remain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_cnt_r <= 8'h00;
      end else begin
         err_cnt_r <= err_cnt_r + 8'(rx_push && rx_char_err != 3'b000)
                      - 8'(rx_pop && rx_head[10:8] != 3'b000);
      end
   end

   // ------------------------------------------------------------
   // transmit fifo
   // ------------------------------------------------------------
   logic [7:0] tx_mem [DEPTH];
   logic tx_wr, tx_push, tx_take;
   assign tx_wr = wr_en & hit(paddr, `OFS_RX_TX_HOLD);
   assign tx_push = tx_wr & (tx_cnt < cap); // writes to a full fifo drop
   assign tx_take = tx_pop & (tx_cnt != 8'h00);
   always_ff @(posedge pclk) begin
      if (tx_push) tx_mem[tx_wp_r[AW-1:0]] <= pwdata[7:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_wp_r <= '0;
         tx_rp_r <= '0;
      end else begin
         if (tx_push) tx_wp_r <= tx_wp_r + 1'b1;
         if (tx_take) tx_rp_r <= tx_rp_r + 1'b1;
      end
   end
   assign tx_char = tx_mem[tx_rp_r[AW-1:0]];
   assign tx_char_valid = tx_cnt != 8'h00;

   // ------------------------------------------------------------
   // modem pins: two-stage synchronisers
   // ------------------------------------------------------------
   logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r; // cts, dsr, ri, cd (active low)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r <= 4'hf;
         pin_s2_r <= 4'hf;
         pin_s3_r <= 4'hf;
      end else begin
         pin_s1_r <= {cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r; // previous value for edge detect
      end
   end

   // ------------------------------------------------------------
   // sticky status flags (set wins over clear, except the time-out flag where clear wins)
   // ------------------------------------------------------------
   logic rd_ident, rd_lstat, rd_mstat;
   assign rd_ident = rd_en & hit(paddr, `OFS_IRQ_IDENT);
   assign rd_lstat = rd_en & hit(paddr, `OFS_LINE_STAT);
   assign rd_mstat = rd_en & hit(paddr, `OFS_MODEM_STAT);
   logic overrun_r, halt_irq_r, spec_irq_r, hshake_r, txhold_r, timeout_r;
   logic [3:0] msr_delta_r;
   logic [3:0] pin_chg;
   logic rts_rise;
   logic rts_prev_r;
   assign pin_chg = pin_s2_r ^ pin_s3_r;

   // (R9) overrun held until a line status read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) overrun_r <= 1'b0;
      else overrun_r <= overrun | (overrun_r & ~rd_lstat);
   end
   // (R4) change bits cleared at reset and on modem status read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) msr_delta_r <= 4'h0;
      else msr_delta_r <= pin_chg | (msr_delta_r & {4{~rd_mstat}});
   end
   // (R15) halt flag cleared by resume, special by line status read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_irq_r <= 1'b0;
         spec_irq_r <= 1'b0;
      end else begin
         // (R22) halt char raises the flow flag
         halt_irq_r <= halt_seen | (halt_irq_r & ~resume_seen);
         spec_irq_r <= special_seen | (spec_irq_r & ~rd_lstat);
      end
   end
   // (R12) rts or cts going inactive high, cleared by ident read
   assign rts_rise = rts_n & ~rts_prev_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hshake_r <= 1'b0;
         rts_prev_r <= 1'b1;
      end else begin
         rts_prev_r <= rts_n;
         hshake_r <= (pin_s2_r[0] & ~pin_s3_r[0]) | rts_rise | (hshake_r & ~rd_ident);
      end
   end
   // (R11) tx hold: set at empty / trigger crossing, cleared by ident read or write
   logic tx_room_now, tx_room_prev_r;
   assign tx_room_now = fifo_en ? ((cap - tx_cnt) >= tx_trig) : (tx_cnt == 8'h00);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txhold_r <= 1'b0;
         tx_room_prev_r <= 1'b1;
      end else begin
         tx_room_prev_r <= tx_room_now;
         txhold_r <= (tx_room_now & ~tx_room_prev_r)
                     | (txhold_r & ~rd_ident & ~tx_wr);
      end
   end
   // (R10) time-out on stale rx data, cleared by holding read
   logic [15:0] to_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_cnt_r <= 16'h0000;
         timeout_r <= 1'b0;
      end else if (rx_rd || rx_push || rx_cnt == 8'h00 || !fifo_en) begin
         to_cnt_r <= 16'h0000;
         timeout_r <= 1'b0;
      end else if (to_cnt_r == 16'(TO_CYC - 1)) begin
         timeout_r <= 1'b1;
      end else begin
         to_cnt_r <= to_cnt_r + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // status views
   // ------------------------------------------------------------
   byte_t line_stat_reg, modem_stat_reg;
   logic rx_data_avail, tx_hold_empty;
   assign rx_data_avail = rx_cnt != 8'h00;
   assign tx_hold_empty = tx_cnt == 8'h00;
   // (R3) empty transmitter at reset gives bits 5,6
   // (R14) head error bits, zero when empty
   // (R13) summary bit from error count
   assign line_stat_reg = {err_cnt_r != 8'h00, tx_hold_empty, tx_hold_empty,
                           rx_data_avail ? rx_head[10:8] : 3'b000,
                           overrun_r, rx_data_avail};
   // (R4) upper bits mirror pins (active high view)
   assign modem_stat_reg = {~pin_s2_r[3], ~pin_s2_r[2], ~pin_s2_r[1], ~pin_s2_r[0],
                            msr_delta_r};

   // ------------------------------------------------------------
   // priority and identification
   // ------------------------------------------------------------
   logic [6:0] pend; // enabled pending sources, priority order
   byte_t irq_ident_reg;
   logic rx_above;
   assign rx_above = rx_cnt >= rx_trig;
   // (R7) each source gated by its enable bit, handshake by either of bits 7 and 6
   assign pend = {irq_enable_reg_r[7] | irq_enable_reg_r[`IE_HSHAKE_LO] ? hshake_r : 1'b0,
                  irq_enable_reg_r[5] & (halt_irq_r | spec_irq_r),
                  irq_enable_reg_r[3] & (msr_delta_r != 4'h0),
                  irq_enable_reg_r[1] & txhold_r,
                  irq_enable_reg_r[0] & rx_above,
                  irq_enable_reg_r[0] & timeout_r,
                  irq_enable_reg_r[2] & (overrun_r | err_cnt_r != 8'h00)};
   // (R8) code of the highest pending source
   // (R23) lower sources hidden until higher ones clear
   always_comb begin
      irq_ident_reg = `RST_IRQ_IDENT;
      if (pend[0]) irq_ident_reg = {2'b00, `ID_LINE};
      else if (pend[1]) irq_ident_reg = {2'b00, `ID_TIMEOUT};
      else if (pend[2]) irq_ident_reg = {2'b00, `ID_RXDATA};
      else if (pend[3]) irq_ident_reg = {2'b00, `ID_TXHOLD};
      else if (pend[4]) irq_ident_reg = {2'b00, `ID_MODEM};
      else if (pend[5]) irq_ident_reg = {2'b00, `ID_FLOW};
      else if (pend[6]) irq_ident_reg = {2'b00, `ID_HSHAKE};
   end
   // (R16) any low enable bit puts the channel in interrupt mode
   // (R17) all enables clear keep the output low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq <= 1'b0;
      else irq <= pend != 7'h00;
   end

   chk_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R17
      ({irq_enable_reg_r[7:5], irq_enable_reg_r[3:0]} == 7'h00) |=> !irq)
      else $error("irq active with all enables clear");
   chk_ident_top: assert property (@(posedge pclk) disable iff (!presetn) // R23
      (pend[0]) |-> irq_ident_reg[5:0] == 6'h06)
      else $error("line status not reported first");
   chk_ident_none: assert property (@(posedge pclk) disable iff (!presetn) // R8
      (pend == 7'h00) |-> irq_ident_reg == 8'h01)
      else $error("idle identification not 01");
   chk_irq_follow: assert property (@(posedge pclk) disable iff (!presetn) // R7
      (pend != 7'h00) |=> irq)
      else $error("pending source did not raise irq");
   chk_overrun_clear: assert property (@(posedge pclk) disable iff (!presetn) // R9
      (rd_lstat && !overrun) |=> !overrun_r)
      else $error("overrun survived line status read");
   chk_head_zero: assert property (@(posedge pclk) disable iff (!presetn) // R14
      (rx_cnt == 8'h00) |-> line_stat_reg[4:2] == 3'b000)
      else $error("error bits set with empty fifo");
   chk_hshake_clear: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (rd_ident && !rts_rise && !(pin_s2_r[0] & ~pin_s3_r[0])) |=> !hshake_r)
      else $error("handshake flag survived ident read");
   chk_halt_resume: assert property (@(posedge pclk) disable iff (!presetn) // R15
      (resume_seen && !halt_seen) |=> !halt_irq_r)
      else $error("halt flag survived resume");

   // ------------------------------------------------------------
   // dma ready and serial outputs
   // ------------------------------------------------------------
   // (R6) idle line, rts/dtr inactive, rx ready high in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_out <= 1'b1;
         rts_n <= 1'b1;
         dtr_n <= 1'b1;
         rx_dma_request <= 1'b1;
         tx_dma_request <= 1'b0;
      end else begin
         serial_out <= ~line_ctrl_reg_r[6]; // break forces low; otherwise held high, no data driven here
         rts_n <= ~modem_ctrl_reg_r[1];
         dtr_n <= ~modem_ctrl_reg_r[0];
         if (dma_block) begin
            // (R21) block: trigger spaces / trigger level or time-out
            tx_dma_request <= (tx_cnt < cap) && ((cap - tx_cnt) >= tx_trig);
            rx_dma_request <= (rx_cnt != 8'h00) && (err_cnt_r == 8'h00)
                              && (rx_above || timeout_r);
         end else begin
            // (R20) single: empty transmitter / any char held
            tx_dma_request <= tx_cnt == 8'h00;
            rx_dma_request <= rx_cnt != 8'h00;
         end
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   byte_t rd_byte;
   always_comb begin
      unique case (paddr)
         `OFS_RX_TX_HOLD: rd_byte = rx_head[7:0];
         `OFS_IRQ_ENABLE: rd_byte = irq_enable_reg_r;
         // (R2) no source pending reads 01
         `OFS_IRQ_IDENT: rd_byte = irq_ident_reg;
         `OFS_FIFO_CTRL: rd_byte = fifo_ctrl_reg_r;
         `OFS_LINE_CTRL: rd_byte = line_ctrl_reg_r;
         `OFS_MODEM_CTRL: rd_byte = modem_ctrl_reg_r;
         `OFS_LINE_STAT: rd_byte = line_stat_reg;
         `OFS_MODEM_STAT: rd_byte = modem_stat_reg;
         `OFS_SCRATCH: rd_byte = scratchpad_reg_r;
         `OFS_DIV_LOW: rd_byte = divisor_low_r;
         `OFS_DIV_HIGH: rd_byte = divisor_high_r;
         `OFS_ENH_FEAT: rd_byte = enhanced_feat_reg_r;
         `OFS_FLOW_THRESH: rd_byte = flow_threshold_reg_r;
         `OFS_TRIG_LEVEL: rd_byte = trigger_level_reg_r;
         `OFS_RESUME_ONE: rd_byte = resume_char_one_r;
         `OFS_RESUME_TWO: rd_byte = resume_char_two_r;
         `OFS_HALT_ONE: rd_byte = halt_char_one_r;
         `OFS_HALT_TWO: rd_byte = halt_char_two_r;
         `OFS_FIFO_LEVEL: rd_byte = rx_cnt;
         default: rd_byte = 8'h00; // unmapped reads zero
      endcase
   end
   assign prdata = {24'h000000, rd_byte};
endmodule
`default_nettype wire

//--- tb/apb_host_model.sv
// apb host model that owns the register bus of the channel control block
`timescale 1ns/100ps
`default_nettype none
module apb_host_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // bus idle from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // one transfer; the caller enters right after a rising edge
   // host never enables both flow schemes: enhanced features stay at zero
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // request held until pready is seen high at an edge
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next request never reassigns in this step
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench of the channel control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct packed {logic [11:0] a; logic [7:0] m; logic [7:0] e;} row_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, se;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] rx_char = 8'h00;
   logic [2:0] rx_char_err = 3'b000;
   logic rx_char_valid = 1'b0, tx_pop = 1'b0, cts_n_pin = 1'b1, dsr_n_pin = 1'b1;
   logic halt_seen = 1'b0, resume_seen = 1'b0, special_seen = 1'b0;
   logic serial_out, rts_n, dtr_n, rx_dma_request, tx_dma_request, irq, tx_char_valid;
   logic [7:0] tx_char;
   int errors = 0;
   int comparisons = 0;
   // reset view of the register map, unmapped word last
   row_s rows [0:10] = '{'{12'h004, 8'hff, 8'h00}, '{12'h008, 8'hff, 8'h01},
      '{12'h00c, 8'hff, 8'h00}, '{12'h010, 8'hff, 8'h1d}, '{12'h014, 8'hff, 8'h00},
      '{12'h018, 8'hff, 8'h60}, '{12'h01c, 8'h0f, 8'h00}, '{12'h02c, 8'hff, 8'h00},
      '{12'h030, 8'hff, 8'h00}, '{12'h034, 8'hff, 8'h00}, '{12'h04c, 8'hff, 8'h00}};
   // pin view: tx valid, serial, rts, dtr, rx ready, tx ready, irq
   wire [7:0] pins = {1'b0, tx_char_valid, serial_out, rts_n, dtr_n, rx_dma_request,
      tx_dma_request, irq};
   always #50 pclk = ~pclk;
   uart_irq_ctl uart_irq_ctl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_char(rx_char), .rx_char_err(rx_char_err),
      .rx_char_valid(rx_char_valid), .tx_pop(tx_pop), .cts_n_pin(cts_n_pin),
      .dsr_n_pin(dsr_n_pin), .ri_n_pin(1'b1), .cd_n_pin(1'b1), .halt_seen(halt_seen),
      .resume_seen(resume_seen), .special_seen(special_seen), .serial_out(serial_out),
      .rts_n(rts_n), .dtr_n(dtr_n), .rx_dma_request(rx_dma_request),
      .tx_dma_request(tx_dma_request), .irq(irq), .tx_char(tx_char),
      .tx_char_valid(tx_char_valid));
   apb_host_model apb_host_model_i (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h want %h", $time, w, got, exp);
      end
   endtask
   // read a register and compare under a mask
   task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e,
         input string w);
      apb_host_model_i.xfer(1'b0, a, 32'h0, rd, se);
      chk(rd[7:0] & m, e, w);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb_host_model_i.xfer(1'b1, a, {24'h0, d}, rd, se);
   endtask
   // pins sampled mid-cycle where registered outputs have settled
   task automatic pchk(input logic [7:0] m, input logic [7:0] e, input string w);
      @(negedge pclk);
      chk(pins & m, e, w);
      @(posedge pclk);
   endtask
   // one-cycle event: 0 rx push, 1 tx pop, 2 halt, 3 resume, 4 special
   task automatic pulse(input int k);
      rx_char_valid <= (k == 0);
      tx_pop <= (k == 1);
      halt_seen <= (k == 2);
      resume_seen <= (k == 3);
      special_seen <= (k == 4);
      @(posedge pclk);
      {rx_char_valid, tx_pop, halt_seen, resume_seen, special_seen} <= 5'h00;
      repeat (3) @(posedge pclk);
   endtask
   task automatic summarize();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog well beyond the expected run
   initial begin
      repeat (5000) @(posedge pclk);
      errors++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge pclk);
      pchk(8'h3f, 8'h3c, "reset pins");
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) rdc(rows[i].a, rows[i].m, rows[i].e, "reset reg");
      chk({7'h0, se}, 8'h01, "unmapped slverr");
      wr(12'h020, 8'h5a);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(12'h020, 8'hff, 8'h5a, "scratch kept");
      pchk(8'h02, 8'h02, "tx ready empty");
      wr(12'h004, 8'h07);
      wr(12'h000, 8'ha5);
      pchk(8'h42, 8'h40, "tx ready loaded");
      chk(tx_char, 8'ha5, "tx head");
      pulse(1);
      pchk(8'h03, 8'h03, "tx empty irq");
      rdc(12'h008, 8'h3f, 8'h02, "ident tx");
      rdc(12'h008, 8'h3f, 8'h01, "ident cleared");
      rx_char <= 8'h3c;
      rx_char_err <= 3'b001;
      pulse(0);
      pchk(8'h04, 8'h04, "rx ready");
      rdc(12'h008, 8'h3f, 8'h06, "ident line");
      rdc(12'h018, 8'h9d, 8'h85, "line stat err");
      rdc(12'h008, 8'h3f, 8'h06, "line kept");
      rdc(12'h000, 8'hff, 8'h3c, "rx char");
      pchk(8'h05, 8'h00, "rx ready gone");
      rdc(12'h018, 8'h9d, 8'h00, "line stat clean");
      wr(12'h004, 8'h00);
      rx_char_err <= 3'b000;
      pulse(0);
      pchk(8'h01, 8'h00, "irq polled");
      pulse(0);
      rdc(12'h018, 8'h02, 8'h02, "overrun set");
      rdc(12'h018, 8'h02, 8'h00, "overrun cleared");
      wr(12'h004, 8'h01);
      pchk(8'h01, 8'h01, "irq rx");
      rdc(12'h008, 8'h3f, 8'h04, "ident rx");
      rdc(12'h000, 8'hff, 8'h3c, "rx char two");
      rdc(12'h008, 8'h3f, 8'h01, "rx cleared");
      wr(12'h004, 8'h20);
      pulse(2);
      rdc(12'h008, 8'h3f, 8'h10, "ident halt");
      pulse(3);
      rdc(12'h008, 8'h3f, 8'h01, "halt cleared");
      pulse(4);
      rdc(12'h008, 8'h3f, 8'h10, "ident special");
      rdc(12'h018, 8'hff, 8'h60, "line stat read");
      rdc(12'h008, 8'h3f, 8'h01, "special cleared");
      wr(12'h004, 8'h40);
      cts_n_pin <= 1'b0;
      repeat (5) @(posedge pclk);
      cts_n_pin <= 1'b1;
      repeat (5) @(posedge pclk);
      rdc(12'h008, 8'h3f, 8'h20, "ident hshake");
      rdc(12'h008, 8'h3f, 8'h01, "hshake cleared");
      rdc(12'h01c, 8'hff, 8'h01, "modem stat read");
      wr(12'h004, 8'h08);
      dsr_n_pin <= 1'b0;
      repeat (5) @(posedge pclk);
      rdc(12'h008, 8'h3f, 8'h00, "ident modem");
      rdc(12'h01c, 8'hff, 8'h22, "modem stat read");
      rdc(12'h008, 8'h3f, 8'h01, "modem cleared");
      wr(12'h00c, 8'h09);
      wr(12'h004, 8'h01);
      pulse(0);
      repeat (45) @(posedge pclk);
      rdc(12'h008, 8'h3f, 8'h0c, "ident timeout");
      wr(12'h000, 8'h11);
      pchk(8'h06, 8'h06, "block ready");
      summarize();
   end
endmodule
`default_nettype wire
